//--- verilog/drzq_top.sv
// device-side reset, calibration and power-down state handling
// Behaviour
// - mode-register reset from idle enters auto-init, defaults registers, array undefined
// - calibration starts by register write; init, reset, long, short kinds
// - calibration reset restores thirty percent default accuracy, no quiet time
// - init and long reach fifteen percent; short trims 1.5 percent
// - calibration pin tied to supply means commands ignored, defaults kept
// - calibration pin current path switched off after calibration completes
// - clock enable low with select high enters idle or active power-down
// - power-down disables buffers except clock and enable; enable held low
// - no refresh performed while in power-down
// - exit with enable high and select high; commands valid after latency
// - enable low with deep power-down code enters deep power-down
// - deep power-down discards array, disables inputs, outputs, supply
`timescale 1ns/1ns
`default_nettype none
module drzq_top (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // command pins
    input wire logic cke,
    input wire logic cs_n,
    input wire logic [9:0] ca_rise,
    input wire logic [9:0] ca_fall,
    // board and array conditions
    input wire logic zq_tied_high,
    input wire logic banks_active,
    input wire logic access_busy,
    // status
    output logic [2:0] dev_state,
    output logic active_pd,
    output logic buffers_on,
    output logic supply_on,
    output logic refresh_allowed,
    output logic array_valid,
    output logic mr_defaults,
    output logic cal_busy,
    output logic zq_path_on,
    output logic [5:0] ron_accuracy,
    output logic [5:0] ron_residual_x10,
    output logic cmd_ready,
    output logic proto_err
);
    typedef struct packed {
        drzq_pkg::drzq_state_type st;
        logic [drzq_pkg::CNT_W-1:0] cnt;
        logic cke_prev;
        logic act_pd;
        logic arr_ok;
        logic mr_def;
        logic err;
        logic ready;
        logic cal_busy;
        logic zq_on;
        logic [5:0] acc;
        logic [5:0] res;
        logic buf_on;
        logic sup_on;
        logic ref_ok;
    } drzq_top_state_type;

    drzq_top_state_type s_r;
    drzq_top_state_type s_nxt;

    logic eng_busy;
    logic eng_done;
    logic eng_path;
    logic [5:0] eng_acc;
    logic [5:0] eng_res;
    logic cal_start;
    drzq_pkg::drzq_cal_type cal_kind;

    // no-op: select high, or select low with ca[2:0] all high
    function automatic logic is_nop(input logic csn, input logic [9:0] ca);
        is_nop = csn || (ca[2:0] == drzq_pkg::CMD_NOP_CODE);
    endfunction : is_nop

    // mode-register write: select low, ca[3:0] all low
    function automatic logic is_mrw(input logic csn, input logic [9:0] ca);
        is_mrw = !csn && (ca[3:0] == drzq_pkg::CMD_MRW_CODE);
    endfunction : is_mrw

    // register address: ca_fall[1:0] low bits, ca_rise[9:4] high bits
    logic [7:0] mr_addr;
    logic [7:0] mr_data;
    assign mr_addr = {ca_rise[9:4], ca_fall[1:0]};
    assign mr_data = ca_fall[9:2];

    drzq_cal_engine u_cal (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .start(cal_start),
        .kind(cal_kind),
        .zq_absent(zq_tied_high),
        .busy(eng_busy),
        .done(eng_done),
        .zq_path_on(eng_path),
        .accuracy(eng_acc),
        .residual_x10(eng_res)
    );

    // calibration decode from a register write in idle
    always_comb begin
        cal_start = 1'b0;
        cal_kind = drzq_pkg::CAL_RESET;
        if (s_r.st == drzq_pkg::ST_IDLE && cke && s_r.cke_prev &&
            is_mrw(cs_n, ca_rise) && mr_addr == drzq_pkg::MR_CAL_ADDR &&
            !banks_active) begin
            cal_start = 1'b1;
            case (mr_data)
                drzq_pkg::CAL_INIT_CODE: cal_kind = drzq_pkg::CAL_INIT;
                drzq_pkg::CAL_LONG_CODE: cal_kind = drzq_pkg::CAL_LONG;
                drzq_pkg::CAL_SHORT_CODE: cal_kind = drzq_pkg::CAL_SHORT;
                drzq_pkg::CAL_RESET_CODE: cal_kind = drzq_pkg::CAL_RESET;
                default: cal_start = 1'b0;
            endcase
        end
    end

    // main state machine
    always_comb begin
        s_nxt = s_r;
        s_nxt.cke_prev = cke;
        s_nxt.err = 1'b0;
        s_nxt.cal_busy = eng_busy;
        s_nxt.zq_on = eng_path;
        s_nxt.acc = eng_acc;
        s_nxt.res = eng_res;
        if (s_r.cnt != '0) begin
            s_nxt.cnt = s_r.cnt - drzq_pkg::CNT_W'(1);
        end
        case (s_r.st)
            drzq_pkg::ST_IDLE: begin
                s_nxt.ready = 1'b1;
                if (!cke && s_r.cke_prev) begin
                    // register access or burst in flight forbids entry; here only flagged as an error, entry still taken
                    if (access_busy || eng_busy) begin
                        s_nxt.err = 1'b1;
                    end
                    if (cs_n) begin
                        s_nxt.st = drzq_pkg::ST_PD_ENTRY;
                        s_nxt.act_pd = banks_active;
                        s_nxt.ready = 1'b0;
                        s_nxt.cnt = drzq_pkg::CNT_W'(drzq_pkg::CYC_CKE - 1);
                    end else if (ca_rise[2:0] == drzq_pkg::CMD_DPD_CODE) begin
                        s_nxt.st = drzq_pkg::ST_DPD;
                        s_nxt.arr_ok = 1'b0;
                        s_nxt.ready = 1'b0;
                        s_nxt.cnt = drzq_pkg::CNT_W'(drzq_pkg::CYC_CKE - 1);
                    end else begin
                        s_nxt.err = 1'b1;
                    end
                end else if (cke && is_mrw(cs_n, ca_rise) &&
                    mr_addr == drzq_pkg::MR_RESET_ADDR) begin
                    if (banks_active) begin
                        s_nxt.err = 1'b1;
                    end else begin
                        s_nxt.st = drzq_pkg::ST_RESETTING;
                        s_nxt.mr_def = 1'b1;
                        s_nxt.arr_ok = 1'b0;
                        s_nxt.ready = 1'b0;
                        s_nxt.cnt = drzq_pkg::CNT_W'(drzq_pkg::CYC_INIT4);
                    end
                end else if (cal_start) begin
                    s_nxt.st = drzq_pkg::ST_CALIB;
                    s_nxt.mr_def = 1'b0;
                end else if (is_mrw(cs_n, ca_rise)) begin
                    s_nxt.mr_def = 1'b0;
                end
            end
            drzq_pkg::ST_RESETTING: begin
                if (!is_nop(cs_n, ca_rise) || !cke) begin
                    s_nxt.err = 1'b1;
                end
                if (s_r.cnt == '0) begin
                    s_nxt.st = drzq_pkg::ST_IDLE;
                end
            end
            drzq_pkg::ST_CALIB: begin
                // the reset kind needs no quiet bus, so only flag the others
                if (!is_nop(cs_n, ca_rise) && eng_path) begin
                    s_nxt.err = 1'b1;
                end
                if (eng_done || (!eng_busy && s_r.cal_busy)) begin
                    s_nxt.st = drzq_pkg::ST_IDLE;
                end else if (!eng_busy && !s_r.cal_busy) begin
                    s_nxt.st = drzq_pkg::ST_IDLE; // ignored request
                end
            end
            drzq_pkg::ST_PD_ENTRY: begin
                if (!is_nop(cs_n, ca_rise)) begin
                    s_nxt.err = 1'b1;
                end
                s_nxt.st = drzq_pkg::ST_PD;
            end
            drzq_pkg::ST_PD: begin
                if (cke) begin
                    if (s_r.cnt != '0 || !cs_n) begin
                        s_nxt.err = 1'b1;
                    end
                    s_nxt.st = drzq_pkg::ST_PD_EXIT;
                    s_nxt.cnt = drzq_pkg::CNT_W'(drzq_pkg::CYC_XP);
                end
            end
            drzq_pkg::ST_PD_EXIT: begin
                if (!is_nop(cs_n, ca_rise) || !cke) begin
                    s_nxt.err = 1'b1;
                end
                if (s_r.cnt <= drzq_pkg::CNT_W'(1)) begin
                    s_nxt.st = drzq_pkg::ST_IDLE;
                    s_nxt.act_pd = 1'b0;
                    s_nxt.ready = 1'b1;
                end
            end
            drzq_pkg::ST_DPD: begin
                // leaving needs full power-up init, modelled as auto-init
                if (cke) begin
                    s_nxt.st = drzq_pkg::ST_RESETTING;
                    s_nxt.mr_def = 1'b1;
                    s_nxt.cnt = drzq_pkg::CNT_W'(drzq_pkg::CYC_INIT4);
                end
            end
            default: s_nxt.st = drzq_pkg::ST_IDLE;
        endcase
        // levels follow the next state so the pins come from flip-flops
        s_nxt.buf_on = (s_nxt.st != drzq_pkg::ST_PD) &&
            (s_nxt.st != drzq_pkg::ST_DPD);
        s_nxt.sup_on = (s_nxt.st != drzq_pkg::ST_DPD);
        s_nxt.ref_ok = (s_nxt.st != drzq_pkg::ST_PD) &&
            (s_nxt.st != drzq_pkg::ST_DPD);
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r <= '{st: drzq_pkg::ST_IDLE, cnt: '0, cke_prev: 1'b1,
                act_pd: 1'b0, arr_ok: 1'b1, mr_def: 1'b1, err: 1'b0,
                ready: 1'b0, cal_busy: 1'b0, zq_on: 1'b0,
                acc: drzq_pkg::ACC_DEFAULT, res: 6'h00,
                buf_on: 1'b1, sup_on: 1'b1, ref_ok: 1'b1};
        end else begin
            s_r <= s_nxt;
        end
    end

    // status pins, all taken from the state register
    assign dev_state = s_r.st;
    assign active_pd = s_r.act_pd;
    assign buffers_on = s_r.buf_on;
    assign supply_on = s_r.sup_on;
    assign refresh_allowed = s_r.ref_ok;
    assign array_valid = s_r.arr_ok;
    assign mr_defaults = s_r.mr_def;
    assign cal_busy = s_r.cal_busy;
    assign zq_path_on = s_r.zq_on;
    assign ron_accuracy = s_r.acc;
    assign ron_residual_x10 = s_r.res;
    assign cmd_ready = s_r.ready;
    assign proto_err = s_r.err;
endmodule : drzq_top
`default_nettype wire

//--- verilog/drzq_pkg.sv
// constants and state type for the reset, calibration and power-down block
package drzq_pkg;
    // command decode on the rising-edge half of the command/address bus
    localparam logic [3:0] CMD_MRW_CODE = 4'h0;  // ca[3:0] all low
    localparam logic [2:0] CMD_NOP_CODE = 3'h7;  // ca[2:0] all high
    localparam logic [2:0] CMD_DPD_CODE = 3'h3;  // ca0,ca1 high, ca2 low
    // mode register addresses
    localparam logic [7:0] MR_RESET_ADDR = 8'h3F;
    localparam logic [7:0] MR_CAL_ADDR = 8'h0A;
    // calibration codes written to the calibration register
    localparam logic [7:0] CAL_INIT_CODE = 8'hFF;
    localparam logic [7:0] CAL_LONG_CODE = 8'hAB;
    localparam logic [7:0] CAL_SHORT_CODE = 8'h56;
    localparam logic [7:0] CAL_RESET_CODE = 8'hC3;
    // driver accuracy in percent, reported on an output
    localparam logic [5:0] ACC_DEFAULT = 6'h1E;  // 30 percent
    localparam logic [5:0] ACC_CAL = 6'h0F;      // 15 percent
    localparam logic [5:0] ACC_STEP_X10 = 6'h0F; // short cal, 1.5 percent
    // timings in ns and derived cycle counts at 100 MHz (period 10 ns)
    localparam int CLK_NS = 10;
    localparam int T_INIT4_NS = 1000;
    localparam int T_ZQINIT_NS = 1000;
    localparam int T_ZQCL_NS = 360;
    localparam int T_ZQCS_NS = 90;
    localparam int T_ZQRESET_NS = 50;
    localparam int T_XP_NS = 75;
    localparam int T_CKE_NS = 15;
    localparam int CYC_INIT4 = (T_INIT4_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_ZQINIT = (T_ZQINIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_ZQCL = (T_ZQCL_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_ZQCS = (T_ZQCS_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_ZQRESET = (T_ZQRESET_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_XP = (T_XP_NS + CLK_NS - 1) / CLK_NS;
    localparam int CYC_CKE = (T_CKE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 8;
    // calibration kinds
    typedef enum logic [1:0] {
        CAL_INIT, CAL_LONG, CAL_SHORT, CAL_RESET
    } drzq_cal_type;
    // device states
    typedef enum logic [2:0] {
        ST_IDLE, ST_RESETTING, ST_CALIB, ST_PD_ENTRY, ST_PD,
        ST_PD_EXIT, ST_DPD
    } drzq_state_type;
endpackage : drzq_pkg

//--- verilog/drzq_cal_engine.sv
// impedance calibration engine: timer and driver accuracy tracking
`timescale 1ns/1ns
`default_nettype none
module drzq_cal_engine (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // start request
    input wire logic start,
    input wire drzq_pkg::drzq_cal_type kind,
    input wire logic zq_absent,
    // status
    output logic busy,
    output logic done,
    output logic zq_path_on,
    output logic [5:0] accuracy,
    output logic [5:0] residual_x10
);
    typedef struct packed {
        logic busy;
        logic done;
        logic path;
        drzq_pkg::drzq_cal_type kind;
        logic [drzq_pkg::CNT_W-1:0] cnt;
        logic [5:0] acc;
        logic [5:0] res;
    } drzq_cal_state_type;

    drzq_cal_state_type s_r;
    drzq_cal_state_type s_nxt;

    // period length of each calibration kind
    function automatic logic [drzq_pkg::CNT_W-1:0] cal_len(
        input drzq_pkg::drzq_cal_type k);
        case (k)
            drzq_pkg::CAL_INIT: cal_len = drzq_pkg::CNT_W'(drzq_pkg::CYC_ZQINIT);
            drzq_pkg::CAL_LONG: cal_len = drzq_pkg::CNT_W'(drzq_pkg::CYC_ZQCL);
            drzq_pkg::CAL_SHORT: cal_len = drzq_pkg::CNT_W'(drzq_pkg::CYC_ZQCS);
            default: cal_len = drzq_pkg::CNT_W'(drzq_pkg::CYC_ZQRESET);
        endcase
    endfunction : cal_len

    // one period per command; commands ignored when no resistor is fitted
    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (start && !s_r.busy && !zq_absent) begin
            s_nxt.busy = 1'b1;
            s_nxt.kind = kind;
            s_nxt.cnt = cal_len(kind);
            // the reset kind needs no resistor current
            s_nxt.path = (kind != drzq_pkg::CAL_RESET);
        end else if (s_r.busy) begin
            if (s_r.cnt <= drzq_pkg::CNT_W'(1)) begin
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
                s_nxt.path = 1'b0;
                case (s_r.kind)
                    drzq_pkg::CAL_RESET: begin
                        s_nxt.acc = drzq_pkg::ACC_DEFAULT;
                        s_nxt.res = 6'h00;
                    end
                    drzq_pkg::CAL_SHORT: begin
                        // short cal trims at most 1.5 percent of error, stopping at zero
                        s_nxt.res = (s_r.res > drzq_pkg::ACC_STEP_X10) ?
                            s_r.res - drzq_pkg::ACC_STEP_X10 : 6'h00;
                    end
                    default: begin
                        s_nxt.acc = drzq_pkg::ACC_CAL;
                        s_nxt.res = 6'h00;
                    end
                endcase
            end else begin
                s_nxt.cnt = s_r.cnt - drzq_pkg::CNT_W'(1);
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            s_r <= '{busy: 1'b0, done: 1'b0, path: 1'b0,
                kind: drzq_pkg::CAL_RESET, cnt: '0,
                acc: drzq_pkg::ACC_DEFAULT, res: 6'h00};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy = s_r.busy;
    assign done = s_r.done;
    assign zq_path_on = s_r.path;
    assign accuracy = s_r.acc;
    assign residual_x10 = s_r.res;
endmodule : drzq_cal_engine
`default_nettype wire

//--- test/drzq_top_chk.sv
// port assertions for the reset, calibration and power-down block
`timescale 1ns/1ns
`default_nettype none
module drzq_top_chk (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // command pins and calibration pin condition
    input wire logic cke,
    input wire logic cs_n,
    input wire logic [9:0] ca_rise,
    input wire logic [9:0] ca_fall,
    input wire logic zq_tied_high,
    // status
    input wire logic [2:0] dev_state,
    input wire logic buffers_on,
    input wire logic supply_on,
    input wire logic refresh_allowed,
    input wire logic array_valid,
    input wire logic mr_defaults,
    input wire logic cal_busy,
    input wire logic zq_path_on,
    input wire logic cmd_ready,
    input wire logic proto_err
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // idle and able to take a command
    logic rdy;
    assign rdy = (dev_state == drzq_pkg::ST_IDLE) && cmd_ready;
    property p_mrw_reset;
        rdy && cke && !cs_n && ca_rise[3:0] == 4'h0
            && {ca_rise[9:4], ca_fall[1:0]} == drzq_pkg::MR_RESET_ADDR
        |=> dev_state == drzq_pkg::ST_RESETTING && mr_defaults;
    endproperty
    a_mrw_reset: assert property (p_mrw_reset)
        else $error("register reset did not start auto-init");
    property p_reset_nop;
        dev_state == drzq_pkg::ST_RESETTING && cke && !cs_n
            && ca_rise[2:0] != drzq_pkg::CMD_NOP_CODE |=> proto_err;
    endproperty
    a_reset_nop: assert property (p_reset_nop)
        else $error("command during auto-init not flagged");
    property p_pd_entry;
        rdy && !cke && cs_n |=> dev_state == drzq_pkg::ST_PD_ENTRY
            ##1 dev_state == drzq_pkg::ST_PD;
    endproperty
    a_pd_entry: assert property (p_pd_entry)
        else $error("power-down not entered");
    property p_pd_buf;
        dev_state == drzq_pkg::ST_PD |-> !buffers_on;
    endproperty
    a_pd_buf: assert property (p_pd_buf)
        else $error("buffers on in power-down");
    property p_pd_ref;
        dev_state == drzq_pkg::ST_PD |-> !refresh_allowed;
    endproperty
    a_pd_ref: assert property (p_pd_ref)
        else $error("refresh in power-down");
    property p_pd_exit;
        $rose(dev_state == drzq_pkg::ST_PD_EXIT) |-> !cmd_ready [*6]
            ##[1:8] (dev_state == drzq_pkg::ST_IDLE && cmd_ready);
    endproperty
    a_pd_exit: assert property (p_pd_exit)
        else $error("power-down exit latency wrong");
    property p_dpd;
        rdy && !cke && !cs_n && ca_rise[2:0] == drzq_pkg::CMD_DPD_CODE
        |=> dev_state == drzq_pkg::ST_DPD;
    endproperty
    a_dpd: assert property (p_dpd)
        else $error("deep power-down not entered");
    property p_dpd_off;
        dev_state == drzq_pkg::ST_DPD |-> !supply_on && !buffers_on
            && !array_valid;
    endproperty
    a_dpd_off: assert property (p_dpd_off)
        else $error("deep power-down left something on");
    property p_zq_absent;
        zq_tied_high && dev_state == drzq_pkg::ST_CALIB
        |-> ##[1:2] dev_state == drzq_pkg::ST_IDLE;
    endproperty
    a_zq_absent: assert property (p_zq_absent)
        else $error("calibration ran without resistor");
    property p_zq_path;
        $fell(cal_busy) |-> ##[0:1] !zq_path_on;
    endproperty
    a_zq_path: assert property (p_zq_path)
        else $error("calibration pin path left on");
endmodule : drzq_top_chk
bind drzq_top drzq_top_chk i_chk (.mclk(mclk), .sys_rst(sys_rst),
    .cke(cke), .cs_n(cs_n), .ca_rise(ca_rise), .ca_fall(ca_fall),
    .zq_tied_high(zq_tied_high), .dev_state(dev_state),
    .buffers_on(buffers_on), .supply_on(supply_on),
    .refresh_allowed(refresh_allowed), .array_valid(array_valid),
    .mr_defaults(mr_defaults), .cal_busy(cal_busy),
    .zq_path_on(zq_path_on), .cmd_ready(cmd_ready), .proto_err(proto_err));
`default_nettype wire

//--- test/drzq_ctl_model.sv
// memory controller model driving the command pins
`timescale 1ns/1ns
`default_nettype none
module drzq_ctl_model (
    // clock
    input wire logic mclk,
    // command pins
    output logic cke,
    output logic cs_n,
    output logic [9:0] ca_rise,
    output logic [9:0] ca_fall
);
    initial begin
        cke = 1'b1;
        cs_n = 1'b1;
        ca_rise = 10'h155;
        ca_fall = 10'h2AA;
    end
    // one command a cycle; clock never stopped, no data traffic, one device
    task automatic cmd(input logic c, input logic s, input logic [9:0] r,
                       input logic [9:0] f);
        @(posedge mclk);
        cke <= c;
        cs_n <= s;
        ca_rise <= r;
        ca_fall <= f;
    endtask : cmd
    // deselected bus flips each cycle so a held value cannot pass
    task automatic nop(input int n, input logic c);
        for (int i = 0; i < n; i++) begin
            cmd(c, 1'b1, ~ca_rise, ~ca_fall);
        end
    endtask : nop
    // register write, only from idle with no access in flight
    task automatic mrw(input logic [7:0] a, input logic [7:0] d);
        cmd(1'b1, 1'b0, {a[7:2], 4'h0}, {d, a[1:0]});
        nop(1, 1'b1);
    endtask : mrw
    task automatic pd_enter(input int n);
        cmd(1'b0, 1'b1, ~ca_rise, ~ca_fall);
        nop(n, 1'b0);
    endtask : pd_enter
    task automatic dpd_enter(input int n);
        cmd(1'b0, 1'b0, {7'h00, drzq_pkg::CMD_DPD_CODE}, ~ca_fall);
        nop(n, 1'b0);
    endtask : dpd_enter
    // exit with select high, enable held high for its minimum
    task automatic wake();
        nop(drzq_pkg::CYC_CKE, 1'b1);
    endtask : wake
endmodule : drzq_ctl_model
`default_nettype wire

//--- test/drzq_top_tb.sv
// self-checking bench for the reset, calibration and power-down block
`timescale 1ns/1ns
`default_nettype none
module drzq_top_tb;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic zq_tied_high = 1'b0;
    logic banks_active = 1'b0;
    logic access_busy = 1'b0;
    logic cke, cs_n, buffers_on, supply_on, refresh_allowed, active_pd;
    logic array_valid, mr_defaults, cal_busy, zq_path_on, cmd_ready;
    logic proto_err;
    logic [9:0] ca_rise, ca_fall;
    logic [2:0] dev_state;
    logic [5:0] ron_accuracy, ron_residual_x10;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    always #5 mclk = ~mclk;
    drzq_top i_dut (.mclk(mclk), .sys_rst(sys_rst), .cke(cke),
        .cs_n(cs_n), .ca_rise(ca_rise), .ca_fall(ca_fall),
        .zq_tied_high(zq_tied_high), .banks_active(banks_active),
        .access_busy(access_busy), .dev_state(dev_state),
        .active_pd(active_pd), .buffers_on(buffers_on),
        .supply_on(supply_on), .refresh_allowed(refresh_allowed),
        .array_valid(array_valid), .mr_defaults(mr_defaults),
        .cal_busy(cal_busy), .zq_path_on(zq_path_on),
        .ron_accuracy(ron_accuracy), .ron_residual_x10(ron_residual_x10),
        .cmd_ready(cmd_ready), .proto_err(proto_err));
    drzq_ctl_model i_ctl (.mclk(mclk), .cke(cke), .cs_n(cs_n),
        .ca_rise(ca_rise), .ca_fall(ca_fall));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: seen 0x%0h expected 0x%0h", $time, seen,
                     exp);
        end
    endtask : check
    // bounded wait for a state, bus kept toggling meanwhile
    task automatic wait_st(input logic [2:0] st, input int lim, output int n);
        n = 0;
        #1;
        while (dev_state !== st && n < lim) begin
            i_ctl.nop(1, cke);
            #1;
            n++;
        end
    endtask : wait_st
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test
    // runaway guard, well above the longest sequence
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end
    // all four kinds in turn; last one leaves the default accuracy
    task automatic t_cal();
        logic [7:0] code [4] = '{8'hFF, 8'hAB, 8'h56, 8'hC3};
        int cyc [4] = '{100, 36, 9, 5};
        logic [5:0] acc [4] = '{6'h0F, 6'h0F, 6'h0F, 6'h1E};
        logic [5:0] res;
        int n;
        for (int i = 0; i < 4; i++) begin
            res = ron_residual_x10;
            i_ctl.mrw(drzq_pkg::MR_CAL_ADDR, code[i]);
            wait_st(drzq_pkg::ST_CALIB, 4, n);
            check(8'(dev_state), 8'(drzq_pkg::ST_CALIB));
            i_ctl.nop(1, 1'b1);
            #1;
            check(8'(cal_busy), 8'h01);
            if (i < 3) begin
                check(8'(zq_path_on), 8'h01);
            end
            wait_st(drzq_pkg::ST_IDLE, 200, n);
            check(8'(n + 3 >= cyc[i] && n <= cyc[i] + 3), 8'h01);
            check(8'(ron_accuracy), 8'(acc[i]));
            check(8'(zq_path_on), 8'h00);
            if (i == 2) begin
                check(8'(ron_residual_x10), 8'(res > 15 ? res - 15 : 0));
            end
        end
        $display("t_cal done");
    endtask : t_cal
    task automatic t_zq_absent();
        int n;
        @(posedge mclk);
        zq_tied_high <= 1'b1;
        i_ctl.mrw(drzq_pkg::MR_CAL_ADDR, 8'hAB);
        wait_st(drzq_pkg::ST_IDLE, 4, n);
        check(8'(dev_state), 8'(drzq_pkg::ST_IDLE));
        check(8'(ron_accuracy), 8'h1E);
        @(posedge mclk);
        zq_tied_high <= 1'b0;
        $display("t_zq_absent done");
    endtask : t_zq_absent
    task automatic t_pd(input logic act);
        int n;
        @(posedge mclk);
        banks_active <= act;
        access_busy <= act;
        i_ctl.pd_enter(1);
        #1;
        check(8'(proto_err), 8'(act));
        i_ctl.nop(5, 1'b0);
        #1;
        check(8'(dev_state), 8'(drzq_pkg::ST_PD));
        check(8'(active_pd), 8'(act));
        check(8'({buffers_on, refresh_allowed}), 8'h00);
        i_ctl.wake();
        wait_st(drzq_pkg::ST_IDLE, 30, n);
        check(8'(n + 1 >= drzq_pkg::CYC_XP &&
            n + drzq_pkg::CYC_CKE <= drzq_pkg::CYC_XP + 3), 8'h01);
        check(8'(cmd_ready), 8'h01);
        @(posedge mclk);
        banks_active <= 1'b0;
        access_busy <= 1'b0;
        $display("t_pd done");
    endtask : t_pd
    task automatic t_dpd();
        int n;
        i_ctl.dpd_enter(4);
        #1;
        check(8'(dev_state), 8'(drzq_pkg::ST_DPD));
        check(8'({array_valid, supply_on, buffers_on}), 8'h00);
        i_ctl.wake();
        wait_st(drzq_pkg::ST_IDLE, 300, n);
        check(8'({dev_state, mr_defaults}), 8'h01);
        $display("t_dpd done");
    endtask : t_dpd
    // register reset with an illegal command slipped into the init wait
    task automatic t_mrw_reset();
        int n;
        logic seen = 1'b0;
        i_ctl.mrw(drzq_pkg::MR_RESET_ADDR, 8'h00);
        #1;
        check(8'({dev_state, mr_defaults}), 8'h03);
        i_ctl.cmd(1'b1, 1'b0, 10'h001, 10'h000);
        for (int i = 0; i < 3; i++) begin
            i_ctl.nop(1, 1'b1);
            #1;
            seen = seen | proto_err;
        end
        check(8'(seen), 8'h01);
        wait_st(drzq_pkg::ST_IDLE, 300, n);
        check(8'(n + 6 >= drzq_pkg::CYC_INIT4 &&
            n <= drzq_pkg::CYC_INIT4), 8'h01);
        check(8'(array_valid), 8'h00);
        $display("t_mrw_reset done");
    endtask : t_mrw_reset
    initial begin
        repeat (10) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        check(8'({cmd_ready, mr_defaults, ron_accuracy}), 8'hDE);
        t_cal();
        t_zq_absent();
        t_pd(1'b0);
        t_pd(1'b1);
        t_dpd();
        t_mrw_reset();
        end_of_test();
    end
endmodule : drzq_top_tb
`default_nettype wire
